/* File: shared/drdbc_cfg.svh */
// Constants for the dual ripple decade/binary counter.
// Assumes inclusion by bare name from design files and the checker.
`ifndef DRDBC_CFG_SVH
`define DRDBC_CFG_SVH

// Number of independent counter halves and stages in each.
`define DRDBC_HALVES 2
`define DRDBC_STAGES 4

// Value of every stage while cleared or in reset.
`define DRDBC_CLEARED_STAGES 4'h0
`define DRDBC_SYNC_RESET 1'b0

// Divide-by-five section: count range and step in 4-2-1 weighting.
`define DRDBC_DIV_FIVE_ZERO 3'h0
`define DRDBC_DIV_FIVE_LAST 3'h4
`define DRDBC_DIV_FIVE_STEP 3'h1

// Bit positions inside one half.
`define DRDBC_DIV_TWO_BIT 0
`define DRDBC_DIV_FIVE_LSB 1
`define DRDBC_DIV_FIVE_MSB 3

`endif

/* File: shared/drdbc_pkg.sv */
// Types shared by the dual ripple counter design files.
// Assumes nothing of its surroundings.
package drdbc_pkg;

    // Which of the two device variants is built.
    typedef enum logic {
        DRDBC_DECADE,
        DRDBC_BINARY
    } drdbc_variant_e;

endpackage

/* File: hdl/drdbc_half.sv */
// One counter half: four stages, decade or modulo-16 behaviour.
// Assumes falling-edge events and clear already synchronised to ref_clk.
`timescale 1ns/100ps
`default_nettype none
`include "drdbc_cfg.svh"

module drdbc_half
    import drdbc_pkg::*;
#(
    parameter drdbc_variant_e variant = DRDBC_DECADE
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Synchronised events
    input wire logic first_fall,
    input wire logic second_fall,
    input wire logic clear,
    // Stage outputs
    output logic [`DRDBC_STAGES-1:0] stage_outputs
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------

    // Next value of the divide-by-five section.
    function automatic logic [2:0] next_div_five(input logic [2:0] count);
        if (count >= `DRDBC_DIV_FIVE_LAST) begin
            return `DRDBC_DIV_FIVE_ZERO;
        end
        return count + `DRDBC_DIV_FIVE_STEP;
    endfunction

    logic [`DRDBC_STAGES-1:0] prev_stage;
    logic [`DRDBC_STAGES-1:0] stage_falls;

    assign stage_falls = prev_stage & ~stage_outputs;

    // ------------------------------------------------------------------
    // Previous stage values, used to see a stage fall
    // ------------------------------------------------------------------

    // Cleared together with the stages so a clear never looks like a fall.
    always_ff @(posedge ref_clk) begin
        if (rst || clear) begin
            prev_stage <= `DRDBC_CLEARED_STAGES;
        end else begin
            prev_stage <= stage_outputs;
        end
    end

    // ------------------------------------------------------------------
    // Divide-by-two stage (first stage in either variant)
    // ------------------------------------------------------------------

    always_ff @(posedge ref_clk) begin
        if (rst || clear) begin
            stage_outputs[`DRDBC_DIV_TWO_BIT] <= 1'b0;
        end else if (first_fall) begin
            stage_outputs[`DRDBC_DIV_TWO_BIT] <=
                ~stage_outputs[`DRDBC_DIV_TWO_BIT];
        end
    end

    // ------------------------------------------------------------------
    // Upper three stages
    // ------------------------------------------------------------------

    if (variant == DRDBC_BINARY) begin : g_binary
        // Each stage toggles one cycle after the stage below falls.
        for (genvar k = 1; k < `DRDBC_STAGES; k++) begin : g_ripple
            always_ff @(posedge ref_clk) begin
                if (rst || clear) begin
                    stage_outputs[k] <= 1'b0;
                end else if (stage_falls[k-1]) begin
                    stage_outputs[k] <= ~stage_outputs[k];
                end
            end
        end
    end else begin : g_decade
        // Runs from its own clock only; shares nothing but the clear and reset.
        always_ff @(posedge ref_clk) begin
            if (rst || clear) begin
                stage_outputs[`DRDBC_DIV_FIVE_MSB:`DRDBC_DIV_FIVE_LSB] <=
                    `DRDBC_DIV_FIVE_ZERO;
            end else if (second_fall) begin
                stage_outputs[`DRDBC_DIV_FIVE_MSB:`DRDBC_DIV_FIVE_LSB] <=
                    next_div_five(stage_outputs[
                        `DRDBC_DIV_FIVE_MSB:`DRDBC_DIV_FIVE_LSB]);
            end
        end
    end

endmodule

`default_nettype wire

/* File: hdl/drdbc_top.sv */
// Dual four-stage ripple counter, decade or modulo-16 variant.
// Assumes all pin inputs are asynchronous to ref_clk and far slower.
`timescale 1ns/100ps
`default_nettype none
`include "drdbc_cfg.svh"

module drdbc_top
    import drdbc_pkg::*;
#(
    parameter drdbc_variant_e variant = DRDBC_DECADE
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Binary variant count clocks, one per half, falling edge active
    input wire logic [`DRDBC_HALVES-1:0] count_clock_n,
    // Decade variant section clocks, one per half, falling edge active
    input wire logic [`DRDBC_HALVES-1:0] div_two_clock_n,
    input wire logic [`DRDBC_HALVES-1:0] div_five_clock_n,
    // Clears, one per half, active high
    input wire logic [`DRDBC_HALVES-1:0] clear_all,
    // Stage outputs of half 0 and half 1
    output logic [`DRDBC_STAGES-1:0] stage_outputs_0,
    output logic [`DRDBC_STAGES-1:0] stage_outputs_1
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------

    // First flops; read only by the second flops below.
    logic [`DRDBC_HALVES-1:0] meta_first;
    logic [`DRDBC_HALVES-1:0] meta_second;
    logic [`DRDBC_HALVES-1:0] meta_clear;
    // Second flops, safe to read.
    logic [`DRDBC_HALVES-1:0] sync_first;
    logic [`DRDBC_HALVES-1:0] sync_second;
    logic [`DRDBC_HALVES-1:0] sync_clear;
    // Previous synchronised clock levels for edge detection.
    logic [`DRDBC_HALVES-1:0] last_first;
    logic [`DRDBC_HALVES-1:0] last_second;

    logic [`DRDBC_HALVES-1:0] first_pin;
    logic [`DRDBC_HALVES-1:0] first_fall;
    logic [`DRDBC_HALVES-1:0] second_fall;

    // The binary variant uses its count clock as the first-stage clock.
    assign first_pin = (variant == DRDBC_BINARY) ? count_clock_n
                                                  : div_two_clock_n;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            meta_first <= {`DRDBC_HALVES{`DRDBC_SYNC_RESET}};
            sync_first <= {`DRDBC_HALVES{`DRDBC_SYNC_RESET}};
        end else begin
            meta_first <= first_pin;
            sync_first <= meta_first;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            meta_second <= {`DRDBC_HALVES{`DRDBC_SYNC_RESET}};
            sync_second <= {`DRDBC_HALVES{`DRDBC_SYNC_RESET}};
        end else begin
            meta_second <= div_five_clock_n;
            sync_second <= meta_second;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            meta_clear <= {`DRDBC_HALVES{`DRDBC_SYNC_RESET}};
            sync_clear <= {`DRDBC_HALVES{`DRDBC_SYNC_RESET}};
        end else begin
            meta_clear <= clear_all;
            sync_clear <= meta_clear;
        end
    end

    // ------------------------------------------------------------------
    // Falling edge detection
    // ------------------------------------------------------------------

    // Reset low so a pin that idles high gives no false edge at start.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            last_first <= {`DRDBC_HALVES{`DRDBC_SYNC_RESET}};
            last_second <= {`DRDBC_HALVES{`DRDBC_SYNC_RESET}};
        end else begin
            last_first <= sync_first;
            last_second <= sync_second;
        end
    end

    assign first_fall = last_first & ~sync_first;
    // The divide-by-five clock has no effect in the binary variant.
    assign second_fall = (variant == DRDBC_DECADE) ?
        (last_second & ~sync_second) : {`DRDBC_HALVES{1'b0}};

    // ------------------------------------------------------------------
    // Counter halves
    // ------------------------------------------------------------------

    // Half 0.
    drdbc_half #(
        .variant(variant)
    ) u_half_0 (
        .ref_clk(ref_clk),
        .rst(rst),
        .first_fall(first_fall[0]),
        .second_fall(second_fall[0]),
        .clear(sync_clear[0]),
        .stage_outputs(stage_outputs_0)
    );

    // Half 1, fully independent of half 0.
    drdbc_half #(
        .variant(variant)
    ) u_half_1 (
        .ref_clk(ref_clk),
        .rst(rst),
        .first_fall(first_fall[1]),
        .second_fall(second_fall[1]),
        .clear(sync_clear[1]),
        .stage_outputs(stage_outputs_1)
    );

    // In the binary variant stage 0 and the upper stages change on separate cycles; decoding them gives glitches, so
    // downstream logic must sample them, never use them as clocks.
    // Feeding stage 3 back to the two-clock gives a square divide-by-ten
    // on stage 0; feeding stage 0 to the five-clock gives BCD counting.

endmodule

`default_nettype wire

/* File: tb/drdbc_props.sv */
// Checker of the dual ripple counter top, bound to every instance.
// Assumes the pin synchroniser latency given for the top.
`timescale 1ns/100ps
`default_nettype none
`include "drdbc_cfg.svh"
module drdbc_props
    import drdbc_pkg::*;
#(
    parameter drdbc_variant_e variant = DRDBC_DECADE
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Pins
    input wire logic [1:0] count_clock_n,
    input wire logic [1:0] div_two_clock_n,
    input wire logic [1:0] div_five_clock_n,
    input wire logic [1:0] clear_all,
    // Stage outputs
    input wire logic [3:0] stage_outputs_0,
    input wire logic [3:0] stage_outputs_1
);
    // --------------------
    // Pin history of half 0
    // --------------------
    logic [5:0] hk;
    logic [5:0] hf;
    logic [5:0] hc;
    wire logic dec = (variant == DRDBC_DECADE);
    wire logic ck = dec ? div_two_clock_n[0] : count_clock_n[0];
    wire logic quiet = (hc == 6'h00) && !clear_all[0];
    always_ff @(posedge ref_clk) begin
        hk <= rst ? 6'h00 : {hk[4:0], ck};
        hf <= rst ? 6'h00 : {hf[4:0], div_five_clock_n[0]};
        hc <= rst ? 6'h00 : {hc[4:0], clear_all[0]};
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_clear_half0: assert property (
        clear_all[0] [*4] |=> stage_outputs_0 == 4'h0)
        else $error("half 0 not held at zero");
    a_clear_half1: assert property (
        clear_all[1] [*4] |=> stage_outputs_1 == 4'h0)
        else $error("half 1 not held at zero");
    a_fall_toggles: assert property (
        $fell(ck) && quiet |-> ##[1:6] $changed(stage_outputs_0[0]))
        else $error("first stage missed a falling edge");
    a_only_on_fall: assert property (
        $changed(stage_outputs_0[0]) && quiet |-> |(hk[5:1] & ~hk[4:0]))
        else $error("first stage moved without a falling edge");
    a_five_on_fall: assert property (
        dec && $changed(stage_outputs_0[3:1]) && quiet
        |-> |(hf[5:1] & ~hf[4:0])) else $error("five section moved alone");
    a_five_step: assert property (
        dec && $changed(stage_outputs_0[3:1]) && quiet
        |-> stage_outputs_0[3:1] == ($past(stage_outputs_0[3:1]) == 3'h4 ?
        3'h0 : $past(stage_outputs_0[3:1]) + 3'h1))
        else $error("five section stepped wrongly");
    a_ripple_order: assert property (
        !dec && $changed(stage_outputs_0[1]) && quiet
        |-> $past(stage_outputs_0[0], 2) && !$past(stage_outputs_0[0]))
        else $error("second stage moved without a fall below");
    a_no_joint_change: assert property (
        !dec && $changed(stage_outputs_0[0]) && quiet
        |-> $stable(stage_outputs_0[3:1]))
        else $error("stages changed together");
endmodule
bind drdbc_top drdbc_props #(.variant(variant)) u_props (
    .ref_clk(ref_clk), .rst(rst), .count_clock_n(count_clock_n),
    .div_two_clock_n(div_two_clock_n), .div_five_clock_n(div_five_clock_n),
    .clear_all(clear_all), .stage_outputs_0(stage_outputs_0),
    .stage_outputs_1(stage_outputs_1));
`default_nettype wire

/* File: tb/drdbc_pulser.sv */
// Pulse source that drives the count clock pins of both halves.
// Assumes it is called just after a rising edge of ref_clk.
`timescale 1ns/100ps
`default_nettype none
module drdbc_pulser (
    // Clock
    input wire logic ref_clk,
    // Count pins, both halves together
    output logic [1:0] pin
);
    // --------------------
    // Clean square pulses
    // --------------------
    initial pin = 2'h3;
    // Each level is held 8 cycles from one clean source.
    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            #1 pin = 2'h0;
            repeat (8) @(posedge ref_clk);
            #1 pin = 2'h3;
            repeat (7) @(posedge ref_clk);
        end
    endtask
endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Testbench of the dual ripple counter, decade and binary variants.
// Assumes the pulse source model and the bound checker.
`timescale 1ns/100ps
`default_nettype none
module tb;
    import drdbc_pkg::*;
    typedef struct {int falls; logic [3:0] bcd, biq, bin;} drdbc_row_s;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [1:0] clear_all = 2'h0;
    logic [1:0] pin;
    logic [3:0] q0, q1, b0, b1;
    int error_cnt = 0;
    int total_checks = 0;
    int done = 0;
    drdbc_row_s rows [7] = '{'{1, 4'h1, 4'h2, 4'h1}, '{4, 4'h4, 4'h8, 4'h4},
        '{5, 4'h5, 4'h1, 4'h5}, '{9, 4'h9, 4'h9, 4'h9},
        '{10, 4'h0, 4'h0, 4'hA}, '{15, 4'h5, 4'h1, 4'hF},
        '{16, 4'h6, 4'h3, 4'h0}};
    // --------------------
    // Design and partner
    // --------------------
    always #5 ref_clk = ~ref_clk;
    drdbc_pulser u_src (.ref_clk(ref_clk), .pin(pin));
    // Half 0 wired as BCD, half 1 as square divide-by-ten.
    drdbc_top #(.variant(DRDBC_DECADE)) u_dut (.ref_clk(ref_clk), .rst(rst),
        .count_clock_n(pin), .div_two_clock_n({q1[3], pin[0]}),
        .div_five_clock_n({pin[1], q0[0]}), .clear_all(clear_all),
        .stage_outputs_0(q0), .stage_outputs_1(q1));
    drdbc_top #(.variant(DRDBC_BINARY)) u_bin (.ref_clk(ref_clk), .rst(rst),
        .count_clock_n(pin), .div_two_clock_n(pin), .div_five_clock_n(pin),
        .clear_all(clear_all), .stage_outputs_0(b0), .stage_outputs_1(b1));
    task automatic check(input logic [3:0] got, exp, input string what);
        total_checks++;
        if (got !== exp) begin
            $display("wrong value at %0t: %s %h not %h", $time, what, got, exp);
            error_cnt++;
        end
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    // --------------------
    // Tests
    // --------------------
    initial begin
        repeat (20) @(posedge ref_clk);
        #1 rst = 1'b0;
        repeat (2) @(posedge ref_clk);
        check({q0 | q1 | b0 | b1}, 4'h0, "after reset");
        foreach (rows[i]) begin
            u_src.pulses(rows[i].falls - done);
            done = rows[i].falls;
            check(q0, rows[i].bcd, "bcd half");
            check(q1, rows[i].biq, "biquinary half");
            check(b0, rows[i].bin, "binary half 0");
            check(b1, rows[i].bin, "binary half 1");
        end
        #1 clear_all = 2'h1;
        u_src.pulses(1);
        check(q0, 4'h0, "cleared bcd half");
        check(b0, 4'h0, "cleared binary half");
        check(q1, 4'h5, "uncleared decade half");
        check(b1, 4'h1, "uncleared binary half");
        #1 clear_all = 2'h0;
        repeat (4) @(posedge ref_clk);
        u_src.pulses(1);
        check(q0, 4'h1, "bcd after clear");
        check(b0, 4'h1, "binary after clear");
        check(q1, 4'h7, "biquinary on");
        check(b1, 4'h2, "binary on");
        #1 clear_all = 2'h2;
        repeat (6) @(posedge ref_clk);
        check(q1, 4'h0, "cleared biquinary half");
        check(b1, 4'h0, "cleared binary half 1");
        check(q0, 4'h1, "bcd half kept");
        check(b0, 4'h1, "binary half 0 kept");
        #1 clear_all = 2'h0;
        repeat (4) @(posedge ref_clk);
        #1 rst = 1'b1;
        repeat (2) @(posedge ref_clk);
        check({q0 | q1 | b0 | b1}, 4'h0, "mid-run reset");
        #1 rst = 1'b0;
        repeat (2) @(posedge ref_clk);
        u_src.pulses(1);
        check(q0, 4'h1, "bcd after reset");
        check(q1, 4'h2, "biquinary after reset");
        check(b0, 4'h1, "binary 0 after reset");
        check(b1, 4'h1, "binary 1 after reset");
        tally_and_finish();
    end
    initial begin
        repeat (1000) @(posedge ref_clk);
        error_cnt++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
